// ==== design/dop_pkg.sv ====
// Behaviour
// - compare destination with compare value when enabled
// - colour registers use only pixel-size low bits
// - plane mask 1 updates bit, 0 keeps
// - masked bits excluded from arithmetic and compare
// - carry mask steers ALU carry propagation
// - mask 0 stops carry, 1 passes it
// - never carry out of pixel msb
// - fixed foreground colour when selected
// - fixed background colour when selected
// - width register holds count minus one
// - height register holds rows minus one
// - mask origin offsets within 0..4095
// - source coordinates sixteen bit, not clamped to 0..4095
// - pattern coordinates sixteen bit, not clamped to 0..4095
// - destination coordinates signed sixteen bit
// - only six coordinates read back
// - source select 00 fixed, 10 map
// - three-bit compare condition inhibits update
package dop_pkg;
  localparam int ADDR_W = 12;
  // printed offsets are word indices; byte address is four times
  localparam logic [7:0] IDX_CMP = 8'h4c;
  localparam logic [7:0] IDX_PMASK = 8'h50;
  localparam logic [7:0] IDX_CMASK = 8'h54;
  localparam logic [7:0] IDX_FG = 8'h58;
  localparam logic [7:0] IDX_BG = 8'h5c;
  localparam logic [7:0] IDX_DIM1 = 8'h60;
  localparam logic [7:0] IDX_DIM2 = 8'h62;
  localparam logic [7:0] IDX_MOX = 8'h6c;
  localparam logic [7:0] IDX_MOY = 8'h6e;
  localparam logic [7:0] IDX_SRCX = 8'h70;
  localparam logic [7:0] IDX_SRCY = 8'h72;
  localparam logic [7:0] IDX_PATX = 8'h74;
  localparam logic [7:0] IDX_PATY = 8'h76;
  localparam logic [7:0] IDX_DSTX = 8'h78;
  localparam logic [7:0] IDX_DSTY = 8'h7a;
  localparam int DIM_W = 12;
  localparam int COORD_W = 16;
  localparam logic [31:0] RESET_VAL = 32'h0;
  // coordinate update select codes from the stepping engine
  localparam logic [2:0] CO_SRCX = 3'h0;
  localparam logic [2:0] CO_SRCY = 3'h1;
  localparam logic [2:0] CO_PATX = 3'h2;
  localparam logic [2:0] CO_PATY = 3'h3;
  localparam logic [2:0] CO_DSTX = 3'h4;
  localparam logic [2:0] CO_DSTY = 3'h5;
  typedef enum logic [1:0] {
    SRC_FIXED = 2'b00,
    SRC_RSV1 = 2'b01,
    SRC_MAP = 2'b10,
    SRC_RSV3 = 2'b11
  } dop_srcsel_e;
  typedef enum logic [2:0] {
    CC_ALWAYS = 3'b000,
    CC_GT = 3'b001,
    CC_EQ = 3'b010,
    CC_LT = 3'b011,
    CC_NEVER = 3'b100,
    CC_GE = 3'b101,
    CC_NE = 3'b110,
    CC_LE = 3'b111
  } dop_cond_e;
  function automatic logic [11:0] byteAddr(input logic [7:0] idx);
    byteAddr = {2'b00, idx, 2'b00};
  endfunction
endpackage

// ==== design/dop_operand_regs.sv ====
module dop_operand_regs #(
  parameter int PIX_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] pixSize,
  input wire logic [1:0] foregroundSourceSelect,
  input wire logic [1:0] backgroundSourceSelect,
  input wire logic cmpEnable,
  input wire logic [2:0] cmpCond,
  input wire logic [PIX_W-1:0] srcPixel,
  input wire logic [PIX_W-1:0] destPixel,
  input wire logic [PIX_W-1:0] mixResult,
  input wire logic [PIX_W-1:0] aluA,
  input wire logic [PIX_W-1:0] aluB,
  input wire logic coordUpdEn,
  input wire logic [2:0] coordUpdSel,
  input wire logic [15:0] coordUpdVal,
  output logic [PIX_W-1:0] fgOperand,
  output logic [PIX_W-1:0] bgOperand,
  output logic [PIX_W-1:0] aluSum,
  output logic [PIX_W-1:0] newDest,
  output logic updateInhibit,
  output logic [12:0] opWidthCount,
  output logic [12:0] opHeightCount,
  output logic [11:0] maskOriginX,
  output logic [11:0] maskOriginY,
  output logic [15:0] sourceX,
  output logic [15:0] sourceY,
  output logic [15:0] patternX,
  output logic [15:0] patternY,
  output logic [15:0] destX,
  output logic [15:0] destY
);
  logic [31:0] cmpVal_q, planeMask_q, carryMask_q, fgColour_q, bgColour_q;
  logic [11:0] width_q, height_q, moX_q, moY_q;
  logic [15:0] srcX_q, srcY_q, patX_q, patY_q, dstX_q, dstY_q;
  logic [31:0] rdata_q, rdata_d;
  logic slverr_q;

  function automatic logic [PIX_W-1:0] sizeMask(input logic [1:0] sz);
    logic [8:0] full;
    full = (9'h1 << (4'h1 << sz)) - 9'h1;
    sizeMask = PIX_W'(full);
  endfunction

  wire logic access = psel && penable;
  wire logic wrEn = access && pwrite;
  wire logic [11:0] a = paddr;
  wire logic hitCmp = a == dop_pkg::byteAddr(dop_pkg::IDX_CMP);
  wire logic hitPm = a == dop_pkg::byteAddr(dop_pkg::IDX_PMASK);
  wire logic hitCm = a == dop_pkg::byteAddr(dop_pkg::IDX_CMASK);
  wire logic hitFg = a == dop_pkg::byteAddr(dop_pkg::IDX_FG);
  wire logic hitBg = a == dop_pkg::byteAddr(dop_pkg::IDX_BG);
  wire logic hitD1 = a == dop_pkg::byteAddr(dop_pkg::IDX_DIM1);
  wire logic hitD2 = a == dop_pkg::byteAddr(dop_pkg::IDX_DIM2);
  wire logic hitMx = a == dop_pkg::byteAddr(dop_pkg::IDX_MOX);
  wire logic hitMy = a == dop_pkg::byteAddr(dop_pkg::IDX_MOY);
  wire logic hitSx = a == dop_pkg::byteAddr(dop_pkg::IDX_SRCX);
  wire logic hitSy = a == dop_pkg::byteAddr(dop_pkg::IDX_SRCY);
  wire logic hitPx = a == dop_pkg::byteAddr(dop_pkg::IDX_PATX);
  wire logic hitPy = a == dop_pkg::byteAddr(dop_pkg::IDX_PATY);
  wire logic hitDx = a == dop_pkg::byteAddr(dop_pkg::IDX_DSTX);
  wire logic hitDy = a == dop_pkg::byteAddr(dop_pkg::IDX_DSTY);
  wire logic hitWo = hitCmp | hitPm | hitCm | hitFg | hitBg | hitD1 | hitD2
    | hitMx | hitMy;
  wire logic hitCo = hitSx | hitSy | hitPx | hitPy | hitDx | hitDy;
  wire logic mapped = hitWo | hitCo;

  // coordinate update from the stepping engine; a software write in the
  // same cycle wins so the last host value is never overwritten silently
  wire logic upSx = coordUpdEn && coordUpdSel == dop_pkg::CO_SRCX;
  wire logic upSy = coordUpdEn && coordUpdSel == dop_pkg::CO_SRCY;
  wire logic upPx = coordUpdEn && coordUpdSel == dop_pkg::CO_PATX;
  wire logic upPy = coordUpdEn && coordUpdSel == dop_pkg::CO_PATY;
  wire logic upDx = coordUpdEn && coordUpdSel == dop_pkg::CO_DSTX;
  wire logic upDy = coordUpdEn && coordUpdSel == dop_pkg::CO_DSTY;

  // write-only registers read back zero
  always_comb
  begin
    rdata_d = 32'h0;
    if (hitSx) rdata_d = {16'h0, srcX_q};
    if (hitSy) rdata_d = {16'h0, srcY_q};
    if (hitPx) rdata_d = {16'h0, patX_q};
    if (hitPy) rdata_d = {16'h0, patY_q};
    if (hitDx) rdata_d = {16'h0, dstX_q};
    if (hitDy) rdata_d = {16'h0, dstY_q};
  end

  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = slverr_q;

  // read data registered in the setup cycle so it stands during access
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end
    else
    begin
      rdata_q <= (psel && !penable && !pwrite) ? rdata_d : 32'h0;
      slverr_q <= psel && !penable && !mapped;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmpVal_q <= dop_pkg::RESET_VAL;
      planeMask_q <= dop_pkg::RESET_VAL;
      carryMask_q <= dop_pkg::RESET_VAL;
      fgColour_q <= dop_pkg::RESET_VAL;
      bgColour_q <= dop_pkg::RESET_VAL;
      width_q <= 12'h0;
      height_q <= 12'h0;
      moX_q <= 12'h0;
      moY_q <= 12'h0;
    end
    else if (wrEn)
    begin
      if (hitCmp) cmpVal_q <= pwdata;
      if (hitPm) planeMask_q <= pwdata;
      if (hitCm) carryMask_q <= pwdata;
      if (hitFg) fgColour_q <= pwdata;
      if (hitBg) bgColour_q <= pwdata;
      if (hitD1) width_q <= pwdata[11:0];
      if (hitD2) height_q <= pwdata[11:0];
      if (hitMx) moX_q <= pwdata[11:0];
      if (hitMy) moY_q <= pwdata[11:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      srcX_q <= 16'h0;
      srcY_q <= 16'h0;
      patX_q <= 16'h0;
      patY_q <= 16'h0;
      dstX_q <= 16'h0;
      dstY_q <= 16'h0;
    end
    else
    begin
      if (wrEn && hitSx) srcX_q <= pwdata[15:0];
      else if (upSx) srcX_q <= coordUpdVal;
      if (wrEn && hitSy) srcY_q <= pwdata[15:0];
      else if (upSy) srcY_q <= coordUpdVal;
      if (wrEn && hitPx) patX_q <= pwdata[15:0];
      else if (upPx) patX_q <= coordUpdVal;
      if (wrEn && hitPy) patY_q <= pwdata[15:0];
      else if (upPy) patY_q <= coordUpdVal;
      if (wrEn && hitDx) dstX_q <= pwdata[15:0];
      else if (upDx) dstX_q <= coordUpdVal;
      if (wrEn && hitDy) dstY_q <= pwdata[15:0];
      else if (upDy) dstY_q <= coordUpdVal;
    end
  end

  assign opWidthCount = {1'b0, width_q} + 13'h1;
  assign opHeightCount = {1'b0, height_q} + 13'h1;
  assign maskOriginX = moX_q;
  assign maskOriginY = moY_q;
  assign sourceX = srcX_q;
  assign sourceY = srcY_q;
  assign patternX = patX_q;
  assign patternY = patY_q;
  assign destX = dstX_q; // signed form kept as written
  assign destY = dstY_q;

  // pixel-width datapath views of the colour registers
  wire logic [PIX_W-1:0] szMask = sizeMask(pixSize);
  wire logic [PIX_W-1:0] cmpV = cmpVal_q[PIX_W-1:0] & szMask;
  wire logic [PIX_W-1:0] pMask = planeMask_q[PIX_W-1:0] & szMask;
  wire logic [PIX_W-1:0] cMask = carryMask_q[PIX_W-1:0] & szMask;
  wire logic [PIX_W-1:0] fgV = fgColour_q[PIX_W-1:0] & szMask;
  wire logic [PIX_W-1:0] bgV = bgColour_q[PIX_W-1:0] & szMask;

  // reserved select codes yield zero rather than stale data
  always_comb
  begin
    unique case (dop_pkg::dop_srcsel_e'(foregroundSourceSelect))
      dop_pkg::SRC_FIXED: fgOperand = fgV;
      dop_pkg::SRC_MAP: fgOperand = srcPixel & szMask;
      default: fgOperand = '0;
    endcase
    unique case (dop_pkg::dop_srcsel_e'(backgroundSourceSelect))
      dop_pkg::SRC_FIXED: bgOperand = bgV;
      dop_pkg::SRC_MAP: bgOperand = srcPixel & szMask;
      default: bgOperand = '0;
    endcase
  end

  // segmented adder: only write-enabled bits take part
  logic [PIX_W:0] cy;
  always_comb
  begin
    cy = '0;
    aluSum = '0;
    for (int i = 0; i < PIX_W; i++)
    begin
      aluSum[i] = (aluA[i] ^ aluB[i] ^ cy[i]) & pMask[i];
      // carry passes only where the mask allows and never past the
      // pixel msb
      cy[i+1] = ((aluA[i] & aluB[i]) | (cy[i] & (aluA[i] ^ aluB[i])))
        & pMask[i] & cMask[i] & szMask[i] & (i + 1 < PIX_W ? szMask[i+1]
        : 1'b0);
    end
  end

  wire logic [PIX_W-1:0] dMasked = destPixel & pMask;
  wire logic [PIX_W-1:0] cMasked = cmpV & pMask;
  wire logic dGt = dMasked > cMasked;
  wire logic dEq = dMasked == cMasked;
  logic condHit;
  always_comb
  begin
    unique case (dop_pkg::dop_cond_e'(cmpCond))
      dop_pkg::CC_ALWAYS: condHit = 1'b1;
      dop_pkg::CC_GT: condHit = dGt;
      dop_pkg::CC_EQ: condHit = dEq;
      dop_pkg::CC_LT: condHit = !dGt && !dEq;
      dop_pkg::CC_NEVER: condHit = 1'b0;
      dop_pkg::CC_GE: condHit = dGt || dEq;
      dop_pkg::CC_NE: condHit = !dEq;
      dop_pkg::CC_LE: condHit = !dGt;
    endcase
  end
  assign updateInhibit = cmpEnable && condHit;

  assign newDest = ((mixResult & pMask) | (destPixel & ~pMask)) & szMask;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fg_fixed;
    foregroundSourceSelect == 2'b00 |-> fgOperand == (fgColour_q[PIX_W-1:0]
      & szMask);
  endproperty
  a_fg_fixed: assert property (p_fg_fixed) else $error("fg operand");

  property p_bg_map;
    backgroundSourceSelect == 2'b10 |-> bgOperand == (srcPixel & szMask);
  endproperty
  a_bg_map: assert property (p_bg_map) else $error("bg operand");

  property p_keep_bits;
    ((newDest ^ destPixel) & ~pMask & szMask) == '0;
  endproperty
  a_keep_bits: assert property (p_keep_bits) else $error("plane mask");

  property p_width_write;
    wrEn && hitD1 |=> opWidthCount == {1'b0, $past(pwdata[11:0])} + 13'h1;
  endproperty
  a_width_write: assert property (p_width_write)
    else $error("width count");

  property p_height_write;
    wrEn && hitD2 |=> opHeightCount == {1'b0, $past(pwdata[11:0])} + 13'h1;
  endproperty
  a_height_write: assert property (p_height_write)
    else $error("height count");

  property p_wo_read_zero;
    psel && !penable && !pwrite && hitWo |=> prdata == 32'h0;
  endproperty
  a_wo_read_zero: assert property (p_wo_read_zero)
    else $error("wo readback");

  property p_dstx_read;
    psel && !penable && !pwrite && hitDx && !upDx ##1 penable
      |-> prdata == {16'h0, dstX_q};
  endproperty
  a_dstx_read: assert property (p_dstx_read) else $error("dest x read");

  property p_never_inhibit;
    cmpCond == 3'b100 |-> !updateInhibit;
  endproperty
  a_never_inhibit: assert property (p_never_inhibit)
    else $error("never cond");

  property p_cmp_off;
    !cmpEnable |-> !updateInhibit;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("compare off");

  property p_no_carry_all;
    carryMask_q == 32'h0 |-> aluSum == ((aluA ^ aluB) & pMask);
  endproperty
  a_no_carry_all: assert property (p_no_carry_all)
    else $error("carry leak");

  property p_hold;
    !wrEn && !coordUpdEn |=> $stable(srcX_q) && $stable(dstY_q)
      && $stable(fgColour_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved");

  c_fg_write: cover property (wrEn && hitFg);
  c_coord_read: cover property (access && !pwrite && hitSy);
  c_inhibit: cover property (updateInhibit && cmpCond == 3'b010);
  c_bad_addr: cover property (pslverr && access);
endmodule

// ==== verif/test_drawing_operand_registers.sv ====
module test_drawing_operand_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, cmpEnable = 1'b0;
  logic [1:0] pixSize = 2'h3, fgSel = 2'h0, bgSel = 2'h0;
  logic [2:0] cmpCond = 3'h0, coordUpdSel = 3'h0;
  logic [7:0] srcPixel = 8'h0, destPixel = 8'h0, mixResult = 8'h0;
  logic [7:0] aluA = 8'h0, aluB = 8'h0, fgOperand, bgOperand, aluSum, newDest;
  logic coordUpdEn = 1'b0, updateInhibit;
  logic [15:0] coordUpdVal = 16'h0;
  logic [12:0] opWidthCount, opHeightCount;
  logic [11:0] maskOriginX, maskOriginY;
  logic [15:0] sourceX, sourceY, patternX, patternY, destX, destY;
  wire logic [95:0] coAll = {destY, destX, patternY, patternX, sourceY, sourceX};
  int n_mismatch = 0;
  int n_compared = 0;
  dop_operand_regs #(.PIX_W(8)) uut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pixSize(pixSize),
    .foregroundSourceSelect(fgSel), .backgroundSourceSelect(bgSel),
    .cmpEnable(cmpEnable), .cmpCond(cmpCond), .srcPixel(srcPixel),
    .destPixel(destPixel), .mixResult(mixResult), .aluA(aluA), .aluB(aluB),
    .coordUpdEn(coordUpdEn), .coordUpdSel(coordUpdSel),
    .coordUpdVal(coordUpdVal), .fgOperand(fgOperand), .bgOperand(bgOperand),
    .aluSum(aluSum), .newDest(newDest), .updateInhibit(updateInhibit),
    .opWidthCount(opWidthCount), .opHeightCount(opHeightCount),
    .maskOriginX(maskOriginX), .maskOriginY(maskOriginY), .sourceX(sourceX),
    .sourceY(sourceY), .patternX(patternX), .patternY(patternY),
    .destX(destX), .destY(destY));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // answer is taken at the ready edge, before that edge's updates land
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (psel && penable && pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      n_mismatch++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
    input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0, rd, err);
    chk(rd, exp);
    chk(32'(err), 32'(expErr));
  endtask
  // two edges: registers launched by the first are settled at the second
  task automatic settle();
    @(posedge clk);
    @(posedge clk);
  endtask
  task automatic tReset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(32'(opWidthCount), 32'h1);
    chk(32'(coAll[31:0]), 32'h0);
    chk(32'(destX), 32'h0);
    chk(32'(maskOriginX), 32'h0);
    chk(32'(fgOperand), 32'h0);
    rdchk(dop_pkg::IDX_SRCX, 32'h0, 1'b0);
    $display("reset test done");
  endtask
  task automatic tCoords();
    logic [7:0] ix [6];
    logic [15:0] v [6];
    ix = '{dop_pkg::IDX_SRCX, dop_pkg::IDX_SRCY, dop_pkg::IDX_PATX,
      dop_pkg::IDX_PATY, dop_pkg::IDX_DSTX, dop_pkg::IDX_DSTY};
    // mixed values per coordinate, including a negative destination x of 16'hf800
    v = '{16'h0fff, 16'h0000, 16'h0abc, 16'h0fff, 16'hf800, 16'h17ff};
    for (int i = 0; i < 6; i++)
      wr(ix[i], {16'hffff, v[i]});
    for (int i = 0; i < 6; i++)
    begin
      rdchk(ix[i], {16'h0, v[i]}, 1'b0);
      chk(32'(coAll[i*16 +: 16]), 32'(v[i]));
    end
    $display("coordinate test done");
  endtask
  task automatic tAccess();
    logic [7:0] ix [9];
    ix = '{dop_pkg::IDX_CMP, dop_pkg::IDX_PMASK, dop_pkg::IDX_CMASK,
      dop_pkg::IDX_FG, dop_pkg::IDX_BG, dop_pkg::IDX_DIM1, dop_pkg::IDX_DIM2,
      dop_pkg::IDX_MOX, dop_pkg::IDX_MOY};
    for (int i = 0; i < 9; i++)
    begin
      wr(ix[i], 32'h0000_0aa5);
      rdchk(ix[i], 32'h0, 1'b0);
    end
    wr(8'h7c, 32'h0000_0123);
    rdchk(8'h7c, 32'h0, 1'b1);
    chk(32'(destX), 32'hf800);
    $display("access test done");
  endtask
  task automatic tDims();
    logic [31:0] v [3];
    logic [12:0] e [3];
    v = '{32'h0, 32'h0000_0fff, 32'hffff_f009};
    e = '{13'h0001, 13'h1000, 13'h000a};
    for (int i = 0; i < 3; i++)
    begin
      wr(dop_pkg::IDX_DIM1, v[i]);
      wr(dop_pkg::IDX_DIM2, v[2-i]);
      settle();
      chk(32'(opWidthCount), 32'(e[i]));
      chk(32'(opHeightCount), 32'(e[2-i]));
    end
    wr(dop_pkg::IDX_MOX, 32'h0000_0fff);
    wr(dop_pkg::IDX_MOY, 32'h0000_0123);
    settle();
    chk({4'h0, maskOriginY, 4'h0, maskOriginX}, 32'h0123_0fff);
    $display("dimension test done");
  endtask
  task automatic tOperands();
    logic [7:0] m, e;
    wr(dop_pkg::IDX_FG, 32'hffff_ff5a);
    wr(dop_pkg::IDX_BG, 32'h1234_56c3);
    for (int ps = 0; ps < 4; ps++)
    begin
      pixSize <= 2'(ps);
      settle();
      m = 8'((16'h1 << (1 << ps)) - 16'h1);
      chk(32'(fgOperand), 32'(8'h5a & m));
      chk(32'(bgOperand), 32'(8'hc3 & m));
    end
    srcPixel <= 8'h3c;
    for (int s = 0; s < 4; s++)
    begin
      fgSel <= 2'(s);
      bgSel <= 2'(s);
      settle();
      e = (s == 0) ? 8'h5a : (s == 2) ? 8'h3c : 8'h00;
      chk(32'(fgOperand), 32'(e));
      chk(32'(bgOperand), 32'((s == 0) ? 8'hc3 : e));
    end
    $display("operand test done");
  endtask
  task automatic tAlu();
    logic [7:0] pm [4], cm [4], a [4], b [4], e [4];
    pm = '{8'hff, 8'hff, 8'hff, 8'hf0};
    cm = '{8'h00, 8'hf7, 8'hff, 8'hff};
    a = '{8'hff, 8'h1f, 8'h1f, 8'h0f};
    b = '{8'h01, 8'h01, 8'h01, 8'h01};
    e = '{8'hfe, 8'h10, 8'h20, 8'h00};
    mixResult <= 8'haa;
    destPixel <= 8'h55;
    for (int i = 0; i < 4; i++)
    begin
      wr(dop_pkg::IDX_PMASK, {24'hffffff, pm[i]});
      wr(dop_pkg::IDX_CMASK, {24'hffffff, cm[i]});
      aluA <= a[i];
      aluB <= b[i];
      settle();
      chk(32'(aluSum), 32'(e[i]));
      chk(32'(newDest), 32'((8'haa & pm[i]) | (8'h55 & ~pm[i])));
    end
    // a four-bit pixel whose carry chain is fully open still stops at its msb
    wr(dop_pkg::IDX_PMASK, 32'hffff_ffff);
    pixSize <= 2'h2;
    settle();
    chk(32'(aluSum[4:0]), 32'h0);
    pixSize <= 2'h3;
    $display("alu test done");
  endtask
  task automatic tCompare();
    logic [7:0] d [3];
    logic t;
    d = '{8'h3f, 8'h40, 8'h41};
    wr(dop_pkg::IDX_PMASK, 32'hffff_ffff);
    wr(dop_pkg::IDX_CMP, 32'hffff_ff40);
    cmpEnable <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      destPixel <= d[i/8];
      cmpCond <= 3'(i % 8);
      settle();
      case (i % 8)
        0: t = 1'b1;
        1: t = d[i/8] > 8'h40;
        2: t = d[i/8] == 8'h40;
        3: t = d[i/8] < 8'h40;
        4: t = 1'b0;
        5: t = d[i/8] >= 8'h40;
        6: t = d[i/8] != 8'h40;
        default: t = d[i/8] <= 8'h40;
      endcase
      chk(32'(updateInhibit), 32'(t));
    end
    cmpEnable <= 1'b0;
    cmpCond <= 3'h0;
    settle();
    chk(32'(updateInhibit), 32'h0);
    wr(dop_pkg::IDX_PMASK, 32'h0000_000f);
    wr(dop_pkg::IDX_CMP, 32'h0000_0005);
    cmpEnable <= 1'b1;
    cmpCond <= 3'h2;
    destPixel <= 8'h45;
    settle();
    chk(32'(updateInhibit), 32'h1);
    cmpEnable <= 1'b0;
    $display("compare test done");
  endtask
  task automatic tUpdate();
    coordUpdEn <= 1'b1;
    coordUpdSel <= dop_pkg::CO_DSTX;
    coordUpdVal <= 16'h1234;
    settle();
    chk(32'(destX), 32'h1234);
    coordUpdSel <= dop_pkg::CO_DSTY;
    coordUpdVal <= 16'hfedc;
    settle();
    chk(32'(destY), 32'hfedc);
    coordUpdSel <= 3'h6;
    coordUpdVal <= 16'h5555;
    settle();
    coordUpdEn <= 1'b0;
    chk(32'(coAll[47:16]), 32'h0abc_0000);
    rdchk(dop_pkg::IDX_DSTX, 32'h1234, 1'b0);
    $display("update test done");
  endtask
  initial
  begin
    tReset();
    tCoords();
    tAccess();
    tDims();
    tOperands();
    tAlu();
    tCompare();
    tUpdate();
    tReset();
    test_done();
  end
endmodule
